//--- design/macc_pkg.sv
// Purpose: Constants and types for the memory access timing bridge.
// Assumes: Core clock of 125 MHz, one clock domain.
// Notes: Times keep their own units; cycle counts are derived from them.
// Summary of operation
// - SRAM instruction fetch completes in one cycle.
// - SRAM code: data adds one, flash data three.
// - SRAM code: taken branch adds two refill cycles.
// - Flash is read as sixteen-bit halves.
// - Flash fetch adds two, compressed mode one, at divider zero only.
// - Dead time precedes every flash load and save access.
// - Flash branch: one decode, four refill cycles.
// - Flash data processing: decode plus two halves.
// - One more cycle after flash data processing, with code in flash only.
// - Single flash load: fetch, dead, data cycles.
// - Multiple transfer: N dead, 2N data or programs.
// - Word save two programs, half save one.
// - Page erase 20 ms, half program 50 us.
// - Flash busy stalls flash fetches and accesses.
// - Enabled interrupt aborts erase or program quickly.
// - Peripheral registers occupy top four kilobytes.
// - Peripheral reads are little-endian, any width.
// - Half write clears upper sixteen register bits.
// - Half read returns only sixteen bits.
package macc_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;          // Core clock period.
	localparam int PROG_TIME_NS  = 50000;      // One half-word program.
	localparam int ERASE_TIME_MS = 20;         // One page erase.
	localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES  = (ERASE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam logic [3:0] ABORT_CYCLES = 4'hA; // Typical abort length.
	// ------------------------------------------------------------
	// Cycle figures per access class
	// ------------------------------------------------------------
	localparam logic [5:0] FETCH_EXTRA_FULL = 6'h02; // Full-width fetch.
	localparam logic [5:0] FETCH_EXTRA_COMP = 6'h01; // Compressed fetch.
	localparam logic [5:0] DATA_EXTRA       = 6'h01; // Execute or dead cycle.
	localparam logic [5:0] DECODE_CYCLES    = 6'h01; // New address decode.
	localparam logic [5:0] REFILL_SRAM      = 6'h02; // Refill from SRAM code.
	localparam logic [5:0] REFILL_FLASH     = 6'h04; // Refill from flash code.
	localparam logic [5:0] WORD_HALVES      = 6'h02; // Halves per word.
	localparam logic [5:0] HALF_HALVES      = 6'h01; // Halves per half-word.
	localparam logic [1:0] POST_DATA_CYCLES = 2'h1;  // Gap before next fetch.
	// ------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------
	localparam logic [31:0] PER_BASE   = 32'hFFFF_F000; // Peripheral window.
	localparam logic [31:0] FLASH_BASE = 32'h0008_0000; // Flash window base.
	localparam logic [31:0] FLASH_MASK = 32'hFFF8_0000; // Flash window mask.
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {OP_FETCH, OP_BRANCH, OP_DPROC, OP_WORD_LOAD,
		OP_WORD_SAVE, OP_MULTI_FETCH_STACK, OP_MULTI_SAVE_STACK} macc_op_t;
	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} macc_size_t;
	typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_HALF, ST_POST, ST_PROG,
		ST_DONE} macc_st_t;
endpackage

//--- design/macc_bridge.sv
// Purpose: Access timing bridge between the core, SRAM, flash and peripherals.
// Assumes: The core holds every request input stable until core_ready.
// Notes: Cycle counts per class are fixed; flash busy blocks flash traffic.
`timescale 1ns/1ps
module macc_bridge #(
	parameter int PROG_CYC  = macc_pkg::PROG_CYCLES,  // Program length.
	parameter int ERASE_CYC = macc_pkg::ERASE_CYCLES, // Erase length.
	parameter int CD_W      = 3                       // Divider field width.
) (
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// Core request.
	input  wire logic                 core_req,
	input  wire macc_pkg::macc_op_t   core_op,
	input  wire macc_pkg::macc_size_t core_size,
	input  wire logic [31:0]          core_addr,
	input  wire logic [4:0]           core_count,
	input  wire logic [31:0]          core_wdata,
	input  wire logic                 core_flash_data,
	input  wire logic                 code_in_flash,
	input  wire logic                 compressed_mode,
	input  wire logic [CD_W-1:0]      core_clock_divider_field,
	input  wire logic                 core_irq,
	// Core answer.
	output logic                      core_ready,
	output logic [31:0]               core_rdata,
	// SRAM port.
	output logic                      sram_en,
	output logic                      sram_we,
	output logic [31:0]               sram_addr,
	output logic [31:0]               sram_wdata,
	input  wire logic [31:0]          sram_rdata,
	// Flash array port.
	output logic                      flash_rd_en,
	output logic [31:0]               flash_rd_addr,
	input  wire logic [15:0]          flash_rd_data,
	input  wire logic                 flash_erase_req,
	output logic                      flash_erase_go,
	output logic                      flash_prog_go,
	output logic [31:0]               flash_prog_addr,
	output logic [15:0]               flash_prog_data,
	output logic                      flash_abort_go,
	output logic                      flash_busy,
	output logic                      flash_aborted,
	// Peripheral register port.
	output logic                      per_en,
	output logic                      per_we,
	output logic [11:0]               per_addr,
	output logic [31:0]               per_wdata,
	input  wire logic [31:0]          per_rdata
);
	import macc_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		macc_st_t    st;        // Sequencer state.
		logic [5:0]  w1;        // Wait cycles before data.
		logic [5:0]  h;         // Flash halves still to read.
		logic [5:0]  hidx;      // Current half index.
		logic [1:0]  w2;        // Wait cycles after data.
		logic [5:0]  progs;     // Programs still to run.
		logic [5:0]  pidx;      // Current program half index.
		logic        launched;  // Current program started.
		logic [31:0] rdata;     // Read data to the core.
		logic [21:0] tmr;       // Erase or program timer.
		logic        busy;      // Flash array occupied.
		logic [3:0]  abort_cnt; // Abort countdown, zero when idle.
		logic        aborted;   // Last flash command was aborted.
	} macc_state_t;

	macc_state_t s_r;  // Registered state.
	macc_state_t s_nxt; // Next state.

	logic       is_per;    // Address in the peripheral window.
	logic       is_flash;  // Address in the flash window.
	logic       is_rd;     // Load class.
	logic       is_wr;     // Store class.
	logic       is_multi;  // Multiple transfer class.
	logic       blocked;   // Request must wait for the flash.
	logic       acc;       // Request taken this cycle.
	logic       fin;       // Last cycle before the answer.
	logic [5:0] fx;        // Extra fetch cycles.
	logic [5:0] c_w1;      // Class figures loaded on accept.
	logic [5:0] c_h;
	logic [1:0] c_w2;
	logic [5:0] c_p;
	logic [31:0] rd_src;   // Raw SRAM or peripheral read word.
	logic [31:0] rd_fmt;   // Read word trimmed to the access size.

	// Choose the first phase that still has work, else answer.
	function automatic macc_st_t pick(input logic [5:0] a, input logic [5:0] b,
		input logic [1:0] c, input logic [5:0] d);
		pick = (a != 6'h00) ? ST_PRE : (b != 6'h00) ? ST_HALF :
			(c != 2'h0) ? ST_POST : (d != 6'h00) ? ST_PROG : ST_DONE;
	endfunction

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// Peripheral space wins over any flash window overlap.
	assign is_per   = (core_addr >= PER_BASE);
	assign is_flash = !is_per && ((core_addr & FLASH_MASK) == FLASH_BASE);
	assign is_rd    = (core_op == OP_WORD_LOAD) || (core_op == OP_MULTI_FETCH_STACK);
	assign is_wr    = (core_op == OP_WORD_SAVE) || (core_op == OP_MULTI_SAVE_STACK);
	assign is_multi = (core_op == OP_MULTI_FETCH_STACK) || (core_op == OP_MULTI_SAVE_STACK);
	// Anything touching the array waits out an erase or program.
	assign blocked  = s_r.busy && (code_in_flash || is_flash);
	assign acc      = (s_r.st == ST_IDLE) && core_req && !blocked;

	// ------------------------------------------------------------
	// Class figures
	// ------------------------------------------------------------
	// Fetch cost, then the data, branch or processing overhead per class.
	always_comb begin
		fx   = 6'h00;
		c_w1 = 6'h00;
		c_h  = 6'h00;
		c_w2 = 2'h0;
		c_p  = 6'h00;
		if (code_in_flash && core_clock_divider_field == '0) begin
			fx = compressed_mode ? FETCH_EXTRA_COMP : FETCH_EXTRA_FULL;
		end
		case (core_op)
			OP_FETCH: begin
				c_w1 = fx;
			end
			OP_BRANCH: begin
				// Flash code pays a decode and a longer refill.
				c_w1 = code_in_flash ? fx + DECODE_CYCLES + REFILL_FLASH
					: REFILL_SRAM;
			end
			OP_DPROC: begin
				if (core_flash_data && is_flash) begin
					c_w1 = fx + DECODE_CYCLES;
					c_h  = WORD_HALVES;
					c_w2 = code_in_flash ? POST_DATA_CYCLES : 2'h0;
				end else begin
					c_w1 = fx;
				end
			end
			default: begin
				// Dead time before flash data does not depend on the divider.
				if (is_flash) begin
					c_w1 = fx + (is_multi ? {1'b0, core_count} : DATA_EXTRA);
					if (is_multi) begin
						c_h = is_rd ? {core_count, 1'b0} : 6'h00;
						c_p = is_wr ? {core_count, 1'b0} : 6'h00;
					end else begin
						c_h = !is_rd ? 6'h00 : (core_size == SZ_WORD) ? WORD_HALVES
							: HALF_HALVES;
						c_p = !is_wr ? 6'h00 : (core_size == SZ_WORD) ? WORD_HALVES
							: HALF_HALVES;
					end
				end else begin
					c_w1 = fx + DATA_EXTRA;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Read formatting
	// ------------------------------------------------------------
	// Narrow reads keep the low lanes only, so a half read of a wide
	// register loses its upper bits; the core should use word reads.
	assign rd_src = is_per ? per_rdata : sram_rdata;
	always_comb begin
		case (core_size)
			SZ_BYTE: rd_fmt = {24'h00_0000, rd_src[7:0]};
			SZ_HALF: rd_fmt = {16'h0000, rd_src[15:0]};
			default: rd_fmt = rd_src;
		endcase
	end

	// ------------------------------------------------------------
	// Sequencer and flash engine
	// ------------------------------------------------------------
	// One pass fills the next state for both the access sequencer and
	// the erase or program timer they share.
	always_comb begin
		s_nxt          = s_r;
		flash_prog_go  = 1'b0;
		flash_erase_go = 1'b0;
		flash_abort_go = 1'b0;
		fin            = 1'b0;
		// Ready stays low until every phase of the class is spent or a program is aborted.
		case (s_r.st)
			ST_IDLE: begin
				if (acc) begin
					s_nxt.w1       = c_w1;
					s_nxt.h        = c_h;
					s_nxt.hidx     = 6'h00;
					s_nxt.w2       = c_w2;
					s_nxt.progs    = c_p;
					s_nxt.pidx     = 6'h00;
					s_nxt.launched = 1'b0;
					s_nxt.st       = pick(c_w1, c_h, c_w2, c_p);
				end
			end
			ST_PRE: begin
				if (s_r.w1 == 6'h01) begin
					s_nxt.st = pick(6'h00, s_r.h, s_r.w2, s_r.progs);
				end else begin
					s_nxt.w1 = s_r.w1 - 6'h01;
				end
			end
			ST_HALF: begin
				// Each cycle gathers one half; the word builds low half first.
				if (s_r.hidx[0]) begin
					s_nxt.rdata[31:16] = flash_rd_data;
				end else begin
					s_nxt.rdata[15:0] = flash_rd_data;
					if (core_op == OP_WORD_LOAD && core_size != SZ_WORD) begin
						s_nxt.rdata[31:16] = 16'h0000;
					end
				end
				s_nxt.hidx = s_r.hidx + 6'h01;
				if (s_r.h == 6'h01) begin
					s_nxt.st = pick(6'h00, 6'h00, s_r.w2, s_r.progs);
				end else begin
					s_nxt.h = s_r.h - 6'h01;
				end
			end
			ST_POST: begin
				if (s_r.w2 == 2'h1) begin
					s_nxt.st = pick(6'h00, 6'h00, 2'h0, s_r.progs);
				end else begin
					s_nxt.w2 = s_r.w2 - 2'h1;
				end
			end
			ST_PROG: begin
				if (!s_r.launched && !s_r.busy) begin
					flash_prog_go  = 1'b1;
					s_nxt.launched = 1'b1;
				end else if (s_r.launched && !s_r.busy) begin
					// An aborted store answers at once; the core repeats it.
					if (s_r.aborted || s_r.progs == 6'h01) begin
						s_nxt.st = ST_DONE;
					end else begin
						s_nxt.progs    = s_r.progs - 6'h01;
						s_nxt.pidx     = s_r.pidx + 6'h01;
						s_nxt.launched = 1'b0;
					end
				end
			end
			ST_DONE: begin
				s_nxt.st = ST_IDLE;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
		// SRAM and peripheral traffic happens in the closing cycle.
		fin = (s_nxt.st == ST_DONE) && (s_r.st != ST_DONE);
		if (fin && !is_flash && is_rd) begin
			s_nxt.rdata = rd_fmt;
		end
		// Flash engine: an erase only starts while no program wants it.
		flash_erase_go = flash_erase_req && !s_r.busy && !flash_prog_go;
		if (flash_prog_go || flash_erase_go) begin
			s_nxt.busy    = 1'b1;
			s_nxt.aborted = 1'b0;
			s_nxt.tmr     = flash_prog_go ? 22'(PROG_CYC) : 22'(ERASE_CYC);
		end else if (s_r.busy) begin
			if (s_r.abort_cnt != 4'h0) begin
				if (s_r.abort_cnt == 4'h1) begin
					s_nxt.busy    = 1'b0;
					s_nxt.aborted = 1'b1;
				end
				s_nxt.abort_cnt = s_r.abort_cnt - 4'h1;
			end else if (core_irq) begin
				// The launch cycle is the first of the abort, so the count starts one short.
				flash_abort_go  = 1'b1;
				s_nxt.abort_cnt = ABORT_CYCLES - 4'h1;
			end else if (s_r.tmr == 22'h00_0001) begin
				s_nxt.busy = 1'b0;
			end else begin
				s_nxt.tmr = s_r.tmr - 22'h00_0001;
			end
		end
	end

	// Register the whole state.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign core_ready      = (s_r.st == ST_DONE);
	assign core_rdata      = s_r.rdata;
	assign sram_en         = fin && !is_flash && !is_per && (is_rd || is_wr);
	assign sram_we         = is_wr;
	assign sram_addr       = core_addr;
	assign sram_wdata      = core_wdata;
	assign flash_rd_en     = (s_r.st == ST_HALF);
	assign flash_rd_addr   = core_addr + 32'({s_r.hidx, 1'b0});
	assign flash_prog_addr = core_addr + 32'({s_r.pidx, 1'b0});
	assign flash_prog_data = s_r.pidx[0] ? core_wdata[31:16] : core_wdata[15:0];
	assign flash_busy      = s_r.busy;
	assign flash_aborted   = s_r.aborted;
	assign per_en          = fin && is_per && (is_rd || is_wr);
	assign per_we          = is_wr;
	assign per_addr        = core_addr[11:0];
	// Narrow writes clear the lanes above them.
	assign per_wdata = (core_size == SZ_WORD) ? core_wdata :
		(core_size == SZ_HALF) ? {16'h0000, core_wdata[15:0]}
		: {24'h00_0000, core_wdata[7:0]};

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_sram_fetch_one: assert property (acc && core_op == OP_FETCH && !code_in_flash
		|=> core_ready) else $error("SRAM fetch not one cycle");
	a_sram_data_two: assert property (acc && core_op == OP_WORD_LOAD && !code_in_flash
		&& !is_flash |=> !core_ready ##1 core_ready) else $error("SRAM data not two");
	a_flash_data_four: assert property (acc && core_op == OP_WORD_LOAD && !code_in_flash
		&& is_flash && core_size == SZ_WORD |=> (!core_ready)[*3] ##1 core_ready)
		else $error("Flash word data not four");
	a_sram_branch_three: assert property (acc && core_op == OP_BRANCH
		&& !code_in_flash |=> (!core_ready)[*2] ##1 core_ready)
		else $error("SRAM branch not three");
	a_flash_fetch_full: assert property (acc && core_op == OP_FETCH && code_in_flash
		&& core_clock_divider_field == '0 && !compressed_mode
		|=> (!core_ready)[*2] ##1 core_ready) else $error("Flash fetch not three");
	a_flash_branch_six: assert property (acc && core_op == OP_BRANCH && code_in_flash
		&& core_clock_divider_field != '0 |=> (!core_ready)[*5] ##1 core_ready)
		else $error("Flash branch not six");
	a_dproc_flash_five: assert property (acc && core_op == OP_DPROC && code_in_flash
		&& core_flash_data && is_flash && core_clock_divider_field != '0
		|=> (!core_ready)[*4] ##1 core_ready) else $error("Flash dproc not five");
	a_half_load_three: assert property (acc && core_op == OP_WORD_LOAD
		&& core_size == SZ_HALF && is_flash && code_in_flash
		&& core_clock_divider_field != '0 |=> (!core_ready)[*2] ##1 core_ready)
		else $error("Flash half load not three");
	a_busy_stall: assert property (s_r.st == ST_IDLE && core_req && code_in_flash
		&& flash_busy |=> !core_ready && s_r.st == ST_IDLE) else $error("Fetch not stalled");
	a_abort_ten: assert property (flash_abort_go |=> flash_busy[*8] ##1 flash_busy ##1
		(!flash_busy && flash_aborted)) else $error("Abort length wrong");
	a_prog_hold: assert property (flash_prog_go && !core_irq |=> flash_busy[*8])
		else $error("Program ended early");
	a_per_half_wr: assert property (per_en && per_we && core_size == SZ_HALF
		|-> per_wdata[31:16] == 16'h0000 && core_addr >= PER_BASE)
		else $error("Half write upper lanes not clear");
	a_ready_pulse: assert property (core_ready |=> !core_ready)
		else $error("Ready held past one cycle");

	c_sram_fetch: cover property (acc && core_op == OP_FETCH ##1 core_ready);
	c_flash_save: cover property (flash_prog_go ##[1:20] flash_prog_go);
	c_abort: cover property (flash_abort_go ##10 flash_aborted);
	c_per_read: cover property (per_en && !per_we ##1 core_ready);
endmodule

//--- test/macc_mem_model.sv
// Purpose: Far-side model of the SRAM, the flash array and the peripheral registers.
// Assumes: Reads are asynchronous and the data is a pure function of the address.
// Notes: An unselected output flips every cycle, so stale data can never pass as a match.
`timescale 1ns/1ps
module macc_mem_model (
	// Clock.
	input  wire logic        clk,
	// Read selects and addresses.
	input  wire logic        sram_en,
	input  wire logic [31:0] sram_addr,
	input  wire logic        flash_rd_en,
	input  wire logic [31:0] flash_rd_addr,
	input  wire logic        per_en,
	input  wire logic [11:0] per_addr,
	// Read data.
	output logic [31:0]      sram_rdata,
	output logic [15:0]      flash_rd_data,
	output logic [31:0]      per_rdata
);
	logic tog_r = 1'b0; // Phase of the idle pattern.

	// The idle pattern changes every cycle.
	always @(posedge clk) tog_r <= ~tog_r;

	// The flash hands over one half per read, because the array is sixteen bits wide.
	always_comb begin
		sram_rdata    = sram_en ? (sram_addr ^ 32'h5A5A_0000) : {32{tog_r}};
		flash_rd_data = flash_rd_en ? (flash_rd_addr[15:0] ^ 16'hC3C3) : {16{tog_r}};
		per_rdata     = per_en ? {per_addr, 8'hA5, per_addr} : {32{tog_r}};
	end
endmodule

//--- test/tb_mem_access_wait_state_ctrl.sv
// Purpose: Self-checking bench for the access timing bridge.
// Assumes: Short program and erase lengths through the bridge parameters.
// Notes: The driver queues expected answers; a monitor compares them when ready shows.
`timescale 1ns/1ps
module tb_mem_access_wait_state_ctrl;
	import macc_pkg::*;
	localparam int PC = 8;  // Shortened program length.
	localparam int EC = 30; // Shortened erase length.
	typedef struct {int t; logic ex; logic [31:0] rd; logic ck; int pg; logic [31:0] wd;} macc_note_t;
	logic clk = 0, rst_n = 0, core_req = 0, core_flash_data = 0, code_in_flash = 0;
	logic compressed_mode = 0, core_irq = 0, flash_erase_req = 0;
	macc_op_t core_op = OP_FETCH;
	macc_size_t core_size = SZ_WORD;
	logic [31:0] core_addr = 0, core_wdata = 0, sram_rdata, per_rdata, core_rdata, sram_addr;
	logic [31:0] sram_wdata, flash_rd_addr, flash_prog_addr, per_wdata;
	logic [4:0] core_count = 0;
	logic [2:0] core_clock_divider_field = 0;
	logic [15:0] flash_rd_data, flash_prog_data;
	logic [11:0] per_addr;
	logic core_ready, sram_en, sram_we, flash_rd_en, flash_erase_go, flash_prog_go;
	logic flash_abort_go, flash_busy, flash_aborted, per_en, per_we;
	int fails = 0, num_checks = 0, cyc = 0, progs = 0, seed = 81981, w, fx, n;
	logic [31:0] sa, fa, pa;
	macc_note_t nq[$], nt;

	// ------------------------------------------------------------
	// Design, far side and clock
	// ------------------------------------------------------------
	macc_bridge #(.PROG_CYC(PC), .ERASE_CYC(EC)) macc_bridge_inst (.clk, .rst_n, .core_req,
		.core_op, .core_size, .core_addr, .core_count, .core_wdata, .core_flash_data,
		.code_in_flash, .compressed_mode, .core_clock_divider_field, .core_irq, .core_ready,
		.core_rdata, .sram_en, .sram_we, .sram_addr, .sram_wdata, .sram_rdata, .flash_rd_en,
		.flash_rd_addr, .flash_rd_data, .flash_erase_req, .flash_erase_go, .flash_prog_go,
		.flash_prog_addr, .flash_prog_data, .flash_abort_go, .flash_busy, .flash_aborted,
		.per_en, .per_we, .per_addr, .per_wdata, .per_rdata);
	macc_mem_model macc_mem_model_inst (.clk, .sram_en, .sram_addr, .flash_rd_en,
		.flash_rd_addr, .per_en, .per_addr, .sram_rdata, .flash_rd_data, .per_rdata);
	always #4 clk = ~clk;

	// The cycle counter also cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			fails++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Compare and closing tasks
	// ------------------------------------------------------------
	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_cyc(input int g, input int e);
		num_checks++;
		if (g != e) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic summarize();
		if (fails == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Monitor: each answer takes the oldest note off the queue.
	// ------------------------------------------------------------
	always @(negedge clk) begin
		// Programs run low half first, so the count so far picks the half and address.
		if (flash_prog_go === 1'b1 && nq.size() > 0) begin
			chk_val({16'h0000, flash_prog_data},
				(nq[0].wd >> (progs[0] ? 16 : 0)) & 32'h0000_FFFF);
			chk_val(flash_prog_addr, fa + 32'(2 * progs));
		end
		if (flash_prog_go === 1'b1) progs++;
		if (per_en === 1'b1 && per_we === 1'b1 && nq.size() > 0)
			chk_val(per_wdata, nq[0].wd);
		if (sram_en === 1'b1 && sram_we === 1'b1 && nq.size() > 0)
			chk_val(sram_wdata, nq[0].wd);
		if (core_ready === 1'b1) begin
			if (nq.size() == 0) chk_cyc(1, 0);
			else begin
				nt = nq.pop_front();
				if (nt.ex) chk_cyc(cyc, nt.t);
				else chk_cyc(int'(cyc >= nt.t), 1);
				if (nt.ck) chk_val(core_rdata, nt.rd);
				if (nt.pg >= 0) chk_cyc(progs, nt.pg);
			end
			progs = 0;
		end
	end

	// ------------------------------------------------------------
	// Driver tasks; all changes land on falling edges.
	// ------------------------------------------------------------
	task automatic issue(input macc_op_t op, input macc_size_t sz, input logic [31:0] a,
		input logic [4:0] cnt, input int t, input logic [31:0] rd, input logic ck, input int pg);
		@(negedge clk);
		core_op = op;
		core_size = sz;
		core_addr = a;
		core_count = cnt;
		core_wdata = $random(seed);
		nq.push_back('{cyc + t, 1'b1, rd, ck, pg,
			(sz == SZ_HALF) ? {16'h0000, core_wdata[15:0]} : core_wdata});
		core_req = 1'b1;
	endtask
	// The request is held until the edge that samples ready, then released.
	task automatic wait_done();
		w = 0;
		while (core_ready !== 1'b1 && w < 4000) begin
			@(negedge clk);
			w++;
		end
		@(negedge clk);
		core_req = 1'b0;
	endtask
	task automatic go(input macc_op_t op, input macc_size_t sz, input logic [31:0] a,
		input logic [4:0] cnt, input int t, input logic [31:0] rd, input logic ck, input int pg);
		issue(op, sz, a, cnt, t, rd, ck, pg);
		wait_done();
	endtask
	// A save to flash is judged by its program count and a lower bound on its length.
	task automatic sv(input macc_op_t op, input macc_size_t sz, input logic [4:0] cnt, input int pg);
		issue(op, sz, fa, cnt, 0, 32'h0, 1'b0, pg);
		nq[$].ex = 1'b0;
		nq[$].t = cyc + pg * PC;
		wait_done();
	endtask
	// Starts an erase and counts the cycles that busy stays high.
	task automatic erase_len();
		@(negedge clk) flash_erase_req = 1'b1;
		@(negedge clk) flash_erase_req = 1'b0;
		w = 0;
		while (flash_busy === 1'b1 && w < 4000) begin
			@(negedge clk);
			w++;
		end
	endtask
	function automatic logic [31:0] fw(input logic [31:0] a);
		logic [31:0] b;
		b = a + 32'h0000_0002;
		return {b[15:0] ^ 16'hC3C3, a[15:0] ^ 16'hC3C3};
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		sa = $random(seed) & 32'h0000_FFFC;
		fa = FLASH_BASE | ($random(seed) & 32'h0007_FFF8);
		pa = PER_BASE | ($random(seed) & 32'h0000_0FFC);
		go(OP_FETCH, SZ_WORD, sa, 5'h00, 1, 32'h0, 1'b0, -1);
		go(OP_BRANCH, SZ_WORD, sa, 5'h00, 3, 32'h0, 1'b0, -1);
		go(OP_WORD_LOAD, SZ_WORD, sa, 5'h00, 2, sa ^ 32'h5A5A_0000, 1'b1, -1);
		go(OP_WORD_LOAD, SZ_WORD, fa, 5'h00, 4, fw(fa), 1'b1, -1);
		go(OP_WORD_LOAD, SZ_HALF, fa, 5'h00, 3, {16'h0000, fa[15:0] ^ 16'hC3C3}, 1'b1, -1);
		go(OP_DPROC, SZ_WORD, sa, 5'h00, 1, 32'h0, 1'b0, -1);
		go(OP_WORD_LOAD, SZ_WORD, pa, 5'h00, 2, {pa[11:0], 8'hA5, pa[11:0]}, 1'b1, -1);
		go(OP_WORD_LOAD, SZ_HALF, pa, 5'h00, 2, {16'h0000, 4'h5, pa[11:0]}, 1'b1, -1);
		go(OP_WORD_LOAD, SZ_BYTE, pa, 5'h00, 2, {24'h00_0000, pa[7:0]}, 1'b1, -1);
		go(OP_WORD_SAVE, SZ_WORD, pa, 5'h00, 2, 32'h0, 1'b0, 0);
		go(OP_WORD_SAVE, SZ_HALF, pa, 5'h00, 2, 32'h0, 1'b0, 0);
		go(OP_WORD_SAVE, SZ_WORD, sa, 5'h00, 2, 32'h0, 1'b0, 0);
		// Flash code, each instruction mode at divider zero and nonzero.
		code_in_flash = 1'b1;
		for (int k = 0; k < 4; k++) begin
			compressed_mode = k[0];
			core_clock_divider_field = k[1] ? 3'h3 : 3'h0;
			fx = k[1] ? 0 : (k[0] ? 1 : 2);
			n = k[0] ? 16 : 2;
			go(OP_FETCH, SZ_WORD, fa, 5'h00, 1 + fx, 32'h0, 1'b0, -1);
			go(OP_BRANCH, SZ_WORD, fa, 5'h00, 6 + fx, 32'h0, 1'b0, -1);
			go(OP_WORD_LOAD, SZ_WORD, fa, 5'h00, 4 + fx, fw(fa), 1'b1, -1);
			go(OP_WORD_LOAD, SZ_HALF, fa, 5'h00, 3 + fx, {16'h0000, fa[15:0] ^ 16'hC3C3}, 1'b1, -1);
			core_flash_data = 1'b1;
			go(OP_DPROC, SZ_WORD, fa, 5'h00, 5 + fx, 32'h0, 1'b0, -1);
			core_flash_data = 1'b0;
			go(OP_MULTI_FETCH_STACK, SZ_WORD, fa, n[4:0], 1 + fx + 3 * n, 32'h0, 1'b0, -1);
		end
		code_in_flash = 1'b0;
		sv(OP_WORD_SAVE, SZ_WORD, 5'h00, 2);
		sv(OP_WORD_SAVE, SZ_HALF, 5'h00, 1);
		sv(OP_MULTI_SAVE_STACK, SZ_WORD, 5'h02, 4);
		erase_len();
		chk_cyc(w, EC);
		// A flash fetch waits out an erase that an interrupt cuts short.
		@(negedge clk) flash_erase_req = 1'b1;
		@(negedge clk) flash_erase_req = 1'b0;
		code_in_flash = 1'b1;
		core_clock_divider_field = 3'h0;
		compressed_mode = 1'b0;
		issue(OP_FETCH, SZ_WORD, fa, 5'h00, 0, 32'h0, 1'b0, -1);
		nq[$].ex = 1'b0;
		nq[$].t = cyc + 17;
		repeat (4) @(negedge clk);
		core_irq = 1'b1;
		w = 0;
		while (flash_busy !== 1'b0 && w < 100) begin
			@(negedge clk);
			w++;
		end
		chk_cyc(w, 10);
		chk_val({31'h0, flash_aborted}, 32'h1);
		core_irq = 1'b0;
		wait_done();
		// The erase is issued again after the interrupt and runs to its end.
		code_in_flash = 1'b0;
		erase_len();
		chk_cyc(w, EC);
		summarize();
	end
endmodule
